// >>> hw/emu_pkg.sv
// Constants for the energy meter user data and record block.
// Assumes one module clock; layout codes, byte positions and record constants of the block live here.
package emu_pkg;
    // Cyclic input layout codes
    localparam logic [7:0] CODE_SINGLE = 8'h9F;
    localparam logic [7:0] CODE_REDUCED = 8'h80;
    localparam logic [7:0] CODE_LOST = 8'h00;
    localparam int IN_BYTES = 32;
    // Byte positions of the single-phase layout
    localparam int IB_CODE = 0;
    localparam int IB_QUAL = 1;
    localparam int IB_CUR = 2;
    localparam int IB_VOLT = 4;
    localparam int IB_PACT = 6;
    localparam int IB_PREACT = 8;
    localparam int IB_PAPP = 10;
    localparam int IB_EACT = 12;
    localparam int IB_EREACT = 16;
    localparam int IB_EAPP = 20;
    localparam int IB_SCALE = 24;
    localparam int IB_PF = 31;
    localparam int NUM_SCALE = 7;
    // Output byte 1 control bits
    localparam int OUT_RESET_BIT = 7;
    localparam int OUT_GATE_BIT = 6;
    // Record layout
    localparam logic [6:0] REC_VERSION_OFS = 7'h00;
    localparam logic [6:0] REC_PAD_OFS = 7'h01;
    localparam logic [6:0] REC_CTRL_OFS = 7'h02;
    localparam logic [6:0] REC_START_OFS = 7'h08;
    localparam logic [7:0] REC_VERSION_RESET = 8'h00;
    localparam logic [7:0] REC_PAD_VALUE = 8'h00;
    localparam int CTRL1_DEFER_BIT = 7;
    localparam int SEL_ACTIVE_BIT = 5;
    localparam int SEL_REACTIVE_BIT = 6;
    localparam int SEL_APPARENT_BIT = 7;
    // Meter organisation: five meters per phase, record order
    localparam int NUM_PHASES = 3;
    localparam int METERS_PER_PHASE = 5;
    localparam int NUM_METERS = 15;
    localparam int MK_ACT_IN = 0;
    localparam int MK_ACT_OUT = 1;
    localparam int MK_REACT_IN = 2;
    localparam int MK_REACT_OUT = 3;
    localparam int MK_APP = 4;
    localparam int INC_W = 16;
    // Binary64 fields
    localparam int DBL_FRAC_W = 52;
    localparam logic [10:0] DBL_BIAS = 11'h3FF;
    localparam logic [10:0] DBL_MAX_SHIFT = 11'h03F;
endpackage

// >>> hw/emu_core.sv
// Energy meter user data formatter, output control decoder and meter record.
// Assumes the host's output bytes, measured values and record strobes are
// synchronous to i_clk; power loss of the module is seen as i_rst_b low.
//
// Behaviour
// - Single-phase input byte 0 carries structure code 159.
// - Byte 1 holds quality pair, then current/voltage validity bits from phase 3 to 1.
// - Current, voltage, three powers, three 4-byte energies at fixed byte positions.
// - Seven scaling bytes at 24..30, power factor at byte 31.
// - Reduced layout exchanges exactly two input and two output bytes.
// - Reduced input byte 0 is 0x80, byte 1 the quality flags.
// - Rising bit 7 of output byte 1 resets energy meters; byte 0 reserved.
// - Bit 6 of output byte 1 requests the meter gate open.
// - With gating enabled, energy accumulates only while gate bit is one.
// - With gating disabled, energy accumulates always, gate bit ignored.
// - Meters are volatile and come up zero after supply loss.
// - Normal operation always reports a nonzero structure code.
// - Communication bus failure forces the structure code to zero.
// - Meter-relevant setting change clears meters, counting restarts at zero.
// - Phase 1 supply failure or wrong slot module clears the meters.
// - Record holds all meters per phase, two control bytes per phase at 2..7.
// - Record write loads start values from byte 8 into selected meters only.
// - Record read returns present meter values in the start-value fields.
// - Control byte 1 bit 7 defers start values to reset edge, else immediate.
// - Control byte 2 bits 7,6,5 select apparent, reactive, active meters.

`timescale 1ns/1ps

module emu_core import emu_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Cyclic output data from the host
    input wire logic [7:0] i_out_byte0,
    input wire logic [7:0] i_out_byte1,
    // Configuration and conditions
    input wire logic i_layout_reduced,
    input wire logic i_gate_enable,
    input wire logic i_bus_ok,
    input wire logic i_l1_supply_ok,
    input wire logic i_slot_match,
    input wire logic [3:0] i_meas_type,
    input wire logic [3:0] i_meas_range,
    input wire logic [15:0] i_ct_setting,
    input wire logic i_current_dir,
    // Measured values from the measurement path
    input wire logic [1:0] i_overall_quality_pair,
    input wire logic [3:0] i_upper_phase_valid,
    input wire logic i_phase_one_current_valid,
    input wire logic i_phase_one_voltage_valid,
    input wire logic [15:0] i_phase_one_current,
    input wire logic [15:0] i_phase_one_neutral_voltage,
    input wire logic [15:0] i_active_power,
    input wire logic [15:0] i_reactive_power,
    input wire logic [15:0] i_apparent_power,
    input wire logic [NUM_SCALE-1:0][7:0] i_scaling,
    input wire logic [7:0] i_power_factor,
    input wire logic [NUM_METERS-1:0][INC_W-1:0] i_energy_inc,
    // Acyclic record access, one byte per strobe
    input wire logic [6:0] i_rec_addr,
    input wire logic i_rec_wr,
    input wire logic [7:0] i_rec_wdata,
    input wire logic i_rec_commit,
    input wire logic i_rec_rd,
    output logic [7:0] o_rec_rdata,
    output logic o_rec_rvalid,
    // Cyclic input data to the host
    output logic [IN_BYTES-1:0][7:0] o_in_byte
);

    typedef struct packed {
        logic [NUM_METERS-1:0][63:0] meter;
        logic [NUM_METERS-1:0][63:0] stage;
        logic [NUM_PHASES-1:0][7:0] ctrl_act;
        logic [NUM_PHASES-1:0][7:0] ctrl_sel;
        logic [NUM_PHASES-1:0] pend;
        logic [7:0] version;
        logic reset_bit_q;
        logic [24:0] setting_q;
        logic [IN_BYTES-1:0][7:0] in_byte;
        logic [7:0] rdata;
        logic rvalid;
    } emu_state_type;

    emu_state_type s;
    emu_state_type next_s;

    // Binary64 to unsigned count; negatives become zero, huge values saturate
    function automatic logic [63:0] dbl_to_count(input logic [63:0] d);
        logic [63:0] mant;
        logic [10:0] e;
        mant = {11'h000, 1'b1, d[DBL_FRAC_W-1:0]};
        e = d[62:52] - DBL_BIAS;
        if (d[63] || d[62:52] < DBL_BIAS) begin
            dbl_to_count = 64'h0;
        end else if (e > DBL_MAX_SHIFT) begin
            dbl_to_count = {64{1'b1}};
        end else if (e >= 11'(DBL_FRAC_W)) begin
            dbl_to_count = mant << (e - 11'(DBL_FRAC_W));
        end else begin
            dbl_to_count = mant >> (11'(DBL_FRAC_W) - e);
        end
    endfunction

    // Unsigned count to binary64; low bits past 53 are truncated
    function automatic logic [63:0] count_to_dbl(input logic [63:0] v);
        logic [5:0] p;
        logic [63:0] sh;
        p = 6'h00;
        for (int i = 0; i < 64; i++) begin
            if (v[i]) begin
                p = 6'(i);
            end
        end
        sh = v << (6'h3F - p);
        if (v == 64'h0) begin
            count_to_dbl = 64'h0;
        end else begin
            count_to_dbl = {1'b0, DBL_BIAS + {5'h00, p}, sh[62:11]};
        end
    endfunction

    // Count plus increment, held at all ones instead of wrapping
    function automatic logic [63:0] sat_add(input logic [63:0] a, input logic [INC_W-1:0] b);
        logic [64:0] sum;
        sum = {1'b0, a} + {49'h0, b};
        sat_add = sum[64] ? {64{1'b1}} : sum[63:0];
    endfunction

    // Low 32 bits of a meter for the cyclic image, saturated
    function automatic logic [31:0] sat32(input logic [63:0] v);
        sat32 = (v[63:32] != 32'h0) ? 32'hFFFFFFFF : v[31:0];
    endfunction

    // Whether control byte 2 selects meter kind k
    function automatic logic kind_sel(input logic [7:0] sel, input int k);
        case (k)
            MK_ACT_IN, MK_ACT_OUT: kind_sel = sel[SEL_ACTIVE_BIT];
            MK_REACT_IN, MK_REACT_OUT: kind_sel = sel[SEL_REACTIVE_BIT];
            default: kind_sel = sel[SEL_APPARENT_BIT];
        endcase
    endfunction

    // Next-state logic for the whole block
    always_comb begin
        logic reset_rise;
        logic clear_all;
        logic gate_open;
        logic [24:0] setting_now;
        logic [NUM_PHASES-1:0] apply_now;
        logic [3:0] widx;
        logic [3:0] ridx;
        logic [63:0] rdbl;
        logic [31:0] e_act;
        logic [31:0] e_react;
        logic [31:0] e_app;
        logic [7:0] qual;
        int p;
        reset_rise = 1'b0;
        clear_all = 1'b0;
        gate_open = 1'b0;
        setting_now = '0;
        apply_now = '0;
        widx = '0;
        ridx = '0;
        rdbl = '0;
        e_act = '0;
        e_react = '0;
        e_app = '0;
        qual = '0;
        p = 0;
        next_s = s;

        // Output byte 0 is reserved and not decoded
        reset_rise = i_out_byte1[OUT_RESET_BIT] & ~s.reset_bit_q;
        next_s.reset_bit_q = i_out_byte1[OUT_RESET_BIT];

        // A changed setting restarts counting; first cycle after reset is harmless
        setting_now = {i_meas_type, i_meas_range, i_ct_setting, i_current_dir};
        next_s.setting_q = setting_now;
        clear_all = (setting_now != s.setting_q)
                    | ~i_l1_supply_ok | ~i_slot_match;

        // Gate only matters when gating is enabled by the i_gate_enable input
        gate_open = ~i_gate_enable | i_out_byte1[OUT_GATE_BIT];

        // Record byte writes land in the version, control and staging fields
        if (i_rec_wr) begin
            if (i_rec_addr == REC_VERSION_OFS) begin
                next_s.version = i_rec_wdata;
            end else if (i_rec_addr >= REC_CTRL_OFS && i_rec_addr < REC_START_OFS) begin
                widx = 4'(i_rec_addr - REC_CTRL_OFS);
                if (widx[0]) begin
                    next_s.ctrl_sel[widx[2:1]] = i_rec_wdata;
                end else begin
                    next_s.ctrl_act[widx[2:1]] = i_rec_wdata;
                end
            end else if (i_rec_addr >= REC_START_OFS) begin
                widx = 4'((i_rec_addr - REC_START_OFS) >> 3);
                next_s.stage[widx][i_rec_addr[2:0]*8 +: 8] = i_rec_wdata;
            end
        end

        // Clear pending first, so a deferred commit in the same cycle still arms its phase
        if (clear_all || reset_rise) begin
            next_s.pend = '0;
        end

        // Commit decides per phase: apply now, or wait for the reset edge
        if (i_rec_commit) begin
            for (int ph = 0; ph < NUM_PHASES; ph++) begin
                if (s.ctrl_act[ph][CTRL1_DEFER_BIT]) begin
                    next_s.pend[ph] = 1'b1;
                end else begin
                    apply_now[ph] = 1'b1;
                end
            end
        end

        // Meter update; clear_all wins over loads and accumulation, an immediate load wins over the reset edge
        for (int m = 0; m < NUM_METERS; m++) begin
            p = m / METERS_PER_PHASE;
            if (clear_all) begin
                next_s.meter[m] = 64'h0;
            end else if (apply_now[p] && kind_sel(s.ctrl_sel[p], m % METERS_PER_PHASE)) begin
                next_s.meter[m] = dbl_to_count(s.stage[m]);
            end else if (reset_rise) begin
                if (s.pend[p] && kind_sel(s.ctrl_sel[p], m % METERS_PER_PHASE)) begin
                    next_s.meter[m] = dbl_to_count(s.stage[m]);
                end else begin
                    next_s.meter[m] = 64'h0;
                end
            end else if (gate_open) begin
                next_s.meter[m] = sat_add(s.meter[m], i_energy_inc[m]);
            end
        end
        // Record read returns present meters as binary64, little endian
        next_s.rvalid = i_rec_rd;
        if (i_rec_rd) begin
            if (i_rec_addr == REC_VERSION_OFS) begin
                next_s.rdata = s.version;
            end else if (i_rec_addr == REC_PAD_OFS) begin
                next_s.rdata = REC_PAD_VALUE;
            end else if (i_rec_addr < REC_START_OFS) begin
                widx = 4'(i_rec_addr - REC_CTRL_OFS);
                next_s.rdata = widx[0] ? s.ctrl_sel[widx[2:1]] : s.ctrl_act[widx[2:1]];
            end else begin
                ridx = 4'((i_rec_addr - REC_START_OFS) >> 3);
                rdbl = count_to_dbl(s.meter[ridx]);
                next_s.rdata = rdbl[i_rec_addr[2:0]*8 +: 8];
            end
        end

        // Cyclic input image, multi-byte fields most significant byte first
        qual = {i_overall_quality_pair, i_upper_phase_valid,
                i_phase_one_current_valid, i_phase_one_voltage_valid};
        e_act = sat32(s.meter[MK_ACT_IN]);
        e_react = sat32(s.meter[MK_REACT_IN]);
        e_app = sat32(s.meter[MK_APP]);
        next_s.in_byte = '0;
        if (i_layout_reduced) begin
            // Only two bytes are live; the rest reads zero
            next_s.in_byte[IB_CODE] = CODE_REDUCED;
            next_s.in_byte[IB_QUAL] = qual;
        end else begin
            next_s.in_byte[IB_CODE] = CODE_SINGLE;
            next_s.in_byte[IB_QUAL] = qual;
            {next_s.in_byte[IB_CUR], next_s.in_byte[IB_CUR+1]} = i_phase_one_current;
            {next_s.in_byte[IB_VOLT], next_s.in_byte[IB_VOLT+1]} = i_phase_one_neutral_voltage;
            {next_s.in_byte[IB_PACT], next_s.in_byte[IB_PACT+1]} = i_active_power;
            {next_s.in_byte[IB_PREACT], next_s.in_byte[IB_PREACT+1]} = i_reactive_power;
            {next_s.in_byte[IB_PAPP], next_s.in_byte[IB_PAPP+1]} = i_apparent_power;
            for (int b = 0; b < 4; b++) begin
                next_s.in_byte[IB_EACT+b] = e_act[(3-b)*8 +: 8];
                next_s.in_byte[IB_EREACT+b] = e_react[(3-b)*8 +: 8];
                next_s.in_byte[IB_EAPP+b] = e_app[(3-b)*8 +: 8];
            end
            for (int b = 0; b < NUM_SCALE; b++) begin
                next_s.in_byte[IB_SCALE+b] = i_scaling[b];
            end
            next_s.in_byte[IB_PF] = i_power_factor;
        end
        // A dead communication bus shows as a zero structure code
        if (!i_bus_ok) begin
            next_s.in_byte[IB_CODE] = CODE_LOST;
        end
    end

    // State register; power loss is reset, so meters restart at zero
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s <= '0;
            s.version <= REC_VERSION_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign o_in_byte = s.in_byte;
    assign o_rec_rdata = s.rdata;
    assign o_rec_rvalid = s.rvalid;

endmodule

// >>> tb/emu_monitor.sv
// Checker for the energy meter block: cyclic image layout and record read timing.
// Sees only emu_core ports; bound to it from the testbench top file.
`timescale 1ns/1ps
module emu_monitor import emu_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_bus_ok,
    input wire logic i_layout_reduced,
    input wire logic [1:0] i_overall_quality_pair,
    input wire logic [3:0] i_upper_phase_valid,
    input wire logic i_phase_one_current_valid,
    input wire logic i_phase_one_voltage_valid,
    input wire logic [15:0] i_phase_one_current,
    input wire logic [7:0] i_power_factor,
    input wire logic [6:0] i_rec_addr,
    input wire logic i_rec_rd,
    input wire logic [7:0] o_rec_rdata,
    input wire logic o_rec_rvalid,
    input wire logic [IN_BYTES-1:0][7:0] o_in_byte
);
    // Attempts begin one edge after release; at the release edge the outputs still show reset
    logic run_q;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            run_q <= 1'b0;
        end else begin
            run_q <= 1'b1;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b || !run_q);
    // Layout choice and bus state decide byte 0 one edge later
    sequence s_single; i_bus_ok && !i_layout_reduced; endsequence
    sequence s_reduced; i_bus_ok && i_layout_reduced; endsequence
    // A read answer is a single-cycle pulse unless reads come back to back
    sequence s_answer; o_rec_rvalid ##1 (!o_rec_rvalid || $past(i_rec_rd)); endsequence
    property p_code_single; s_single |=> o_in_byte[0] == 8'h9F; endproperty
    property p_code_reduced; s_reduced |=> o_in_byte[0] == 8'h80; endproperty
    property p_code_lost; !i_bus_ok |=> o_in_byte[0] == 8'h00; endproperty
    property p_quality; 1'b1 |=> o_in_byte[1] == $past({i_overall_quality_pair, i_upper_phase_valid,
        i_phase_one_current_valid, i_phase_one_voltage_valid}); endproperty
    property p_current; !i_layout_reduced |=> {o_in_byte[2], o_in_byte[3]} == $past(i_phase_one_current);
    endproperty
    property p_factor; !i_layout_reduced |=> o_in_byte[31] == $past(i_power_factor); endproperty
    property p_short; i_layout_reduced |=> o_in_byte[31:2] == '0; endproperty
    property p_read; i_rec_rd |=> s_answer; endproperty
    property p_quiet; !i_rec_rd |=> !o_rec_rvalid; endproperty
    property p_pad; i_rec_rd && i_rec_addr == REC_PAD_OFS |=> o_rec_rdata == REC_PAD_VALUE; endproperty
    a_code_single: assert property (p_code_single) else $error("structure code not 9F");
    a_code_reduced: assert property (p_code_reduced) else $error("reduced code not 80");
    a_code_lost: assert property (p_code_lost) else $error("code not zero on bus failure");
    a_quality: assert property (p_quality) else $error("quality byte wrong");
    a_current: assert property (p_current) else $error("current bytes wrong");
    a_factor: assert property (p_factor) else $error("power factor byte wrong");
    a_short: assert property (p_short) else $error("reduced layout longer than two bytes");
    a_read: assert property (p_read) else $error("read answer timing wrong");
    a_quiet: assert property (p_quiet) else $error("read valid without request");
    a_pad: assert property (p_pad) else $error("pad byte not zero");
endmodule

// >>> tb/emu_host.sv
// Host controller model: cyclic output bytes and byte-wise record access.
// Assumes the record port timing of emu_core; changes signals just after edges.
`timescale 1ns/1ps
module emu_host (
    input wire logic i_clk,
    input wire logic [7:0] i_rec_rdata,
    output logic [7:0] o_out_byte0,
    output logic [7:0] o_out_byte1,
    output logic [6:0] o_rec_addr,
    output logic o_rec_wr,
    output logic [7:0] o_rec_wdata,
    output logic o_rec_commit,
    output logic o_rec_rd
);
    // Idle host: reserved byte held zero, no strobes
    initial begin
        o_out_byte0 = 8'h00;
        o_out_byte1 = 8'h00;
        o_rec_addr = 7'h00;
        o_rec_wr = 1'b0;
        o_rec_wdata = 8'h00;
        o_rec_commit = 1'b0;
        o_rec_rd = 1'b0;
    end
    // Record write, least significant byte first; data scrambled once released
    task automatic rec_write(input logic [6:0] a, input int n, input logic [63:0] v);
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            o_rec_wr <= 1'b1;
            o_rec_addr <= a + 7'(i);
            o_rec_wdata <= v[8*i +: 8];
        end
        @(posedge i_clk);
        o_rec_wr <= 1'b0;
        o_rec_wdata <= ~o_rec_wdata;
    endtask
    // Commit on its own cycle so the last staged byte is already registered
    task automatic rec_commit();
        @(posedge i_clk);
        o_rec_commit <= 1'b1;
        @(posedge i_clk);
        o_rec_commit <= 1'b0;
    endtask
    // Back-to-back reads; each byte arrives two edges after it is driven
    task automatic rec_read(input logic [6:0] a, input int n, output logic [63:0] v);
        v = '0;
        for (int i = 0; i < n + 2; i++) begin
            @(posedge i_clk);
            if (i >= 2) v[8*(i-2) +: 8] = i_rec_rdata;
            o_rec_rd <= (i < n);
            o_rec_addr <= a + 7'(i);
        end
    endtask
    // Meter reset request is a rising edge; bit returns low so the next edge is clean
    task automatic reset_edge();
        @(posedge i_clk);
        o_out_byte1[7] <= 1'b1;
        @(posedge i_clk);
        o_out_byte1[7] <= 1'b0;
    endtask
    task automatic set_gate(input logic b);
        @(posedge i_clk);
        o_out_byte1[6] <= b;
    endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for emu_core with the host model on its cyclic and record ports.
// Assumes a 25 MHz clock; meter values are read back through the record as binary64.
`timescale 1ns/1ps
module tb_top import emu_pkg::*;;
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_layout_reduced = 1'b0, i_gate_enable = 1'b0, i_current_dir = 1'b0;
    logic i_bus_ok = 1'b1, i_l1_supply_ok = 1'b1, i_slot_match = 1'b1;
    logic i_phase_one_current_valid = 1'b1, i_phase_one_voltage_valid = 1'b0;
    logic i_rec_wr, i_rec_commit, i_rec_rd, o_rec_rvalid;
    logic [1:0] i_overall_quality_pair = 2'h2;
    logic [3:0] i_upper_phase_valid = 4'hA, i_meas_type = 4'h1, i_meas_range = 4'h2;
    logic [6:0] i_rec_addr;
    logic [7:0] i_out_byte0, i_out_byte1, i_rec_wdata, o_rec_rdata, i_power_factor = 8'h3C;
    logic [15:0] i_ct_setting = 16'h0005, i_phase_one_current = 16'h1234, i_phase_one_neutral_voltage = 16'h5678;
    logic [15:0] i_active_power = 16'h9ABC, i_reactive_power = 16'hDEF0, i_apparent_power = 16'h0F1E;
    logic [NUM_SCALE-1:0][7:0] i_scaling = 56'h11223344556677;
    logic [NUM_METERS-1:0][INC_W-1:0] i_energy_inc = '0;
    logic [IN_BYTES-1:0][7:0] o_in_byte;
    int n_fail = 0, checks = 0;
    // 40 ns period
    always #20 i_clk = ~i_clk;
    emu_core dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_out_byte0(i_out_byte0), .i_out_byte1(i_out_byte1),
        .i_layout_reduced(i_layout_reduced), .i_gate_enable(i_gate_enable), .i_bus_ok(i_bus_ok),
        .i_l1_supply_ok(i_l1_supply_ok), .i_slot_match(i_slot_match), .i_meas_type(i_meas_type),
        .i_meas_range(i_meas_range), .i_ct_setting(i_ct_setting), .i_current_dir(i_current_dir),
        .i_overall_quality_pair(i_overall_quality_pair), .i_upper_phase_valid(i_upper_phase_valid),
        .i_phase_one_current_valid(i_phase_one_current_valid),
        .i_phase_one_voltage_valid(i_phase_one_voltage_valid),
        .i_phase_one_current(i_phase_one_current), .i_phase_one_neutral_voltage(i_phase_one_neutral_voltage),
        .i_active_power(i_active_power), .i_reactive_power(i_reactive_power),
        .i_apparent_power(i_apparent_power), .i_scaling(i_scaling), .i_power_factor(i_power_factor),
        .i_energy_inc(i_energy_inc), .i_rec_addr(i_rec_addr), .i_rec_wr(i_rec_wr), .i_rec_wdata(i_rec_wdata),
        .i_rec_commit(i_rec_commit), .i_rec_rd(i_rec_rd), .o_rec_rdata(o_rec_rdata),
        .o_rec_rvalid(o_rec_rvalid), .o_in_byte(o_in_byte));
    emu_host host (.i_clk(i_clk), .i_rec_rdata(o_rec_rdata), .o_out_byte0(i_out_byte0),
        .o_out_byte1(i_out_byte1), .o_rec_addr(i_rec_addr), .o_rec_wr(i_rec_wr), .o_rec_wdata(i_rec_wdata),
        .o_rec_commit(i_rec_commit), .o_rec_rd(i_rec_rd));
    task automatic check(input string what, input logic [255:0] exp, input logic [255:0] got);
        checks++;
        if (exp !== got) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic meter_is(input int m, input real x);
        logic [63:0] v;
        host.rec_read(7'(8 + 8 * m), 8, v);
        check($sformatf("meter %0d", m), $realtobits(x), v);
    endtask
    // Exactly n edges see the increment on meter 0
    task automatic bump(input int n);
        @(posedge i_clk);
        i_energy_inc[0] <= 16'h0001;
        repeat (n) @(posedge i_clk);
        i_energy_inc[0] <= 16'h0000;
    endtask
    task automatic t_image();
        repeat (2) @(posedge i_clk);
        check("single image", {i_power_factor, i_scaling, 96'h0, i_apparent_power[7:0], i_apparent_power[15:8],
            i_reactive_power[7:0], i_reactive_power[15:8], i_active_power[7:0], i_active_power[15:8],
            i_phase_one_neutral_voltage[7:0], i_phase_one_neutral_voltage[15:8], i_phase_one_current[7:0],
            i_phase_one_current[15:8], 8'hAA, 8'h9F}, o_in_byte);
        i_layout_reduced <= 1'b1;
        repeat (2) @(posedge i_clk);
        check("reduced image", {240'h0, 8'hAA, 8'h80}, o_in_byte);
        i_bus_ok <= 1'b0;
        repeat (2) @(posedge i_clk);
        check("lost code", 8'h00, o_in_byte[0]);
        i_bus_ok <= 1'b1;
        i_layout_reduced <= 1'b0;
    endtask
    task automatic t_gate();
        i_gate_enable <= 1'b1;
        host.set_gate(1'b0);
        bump(10);
        meter_is(0, 0.0);
        host.set_gate(1'b1);
        bump(10);
        meter_is(0, 10.0);
        i_gate_enable <= 1'b0;
        host.set_gate(1'b0);
        bump(5);
        meter_is(0, 15.0);
        check("energy bytes", 32'd15, {o_in_byte[12], o_in_byte[13], o_in_byte[14], o_in_byte[15]});
        i_current_dir <= ~i_current_dir;
        meter_is(0, 0.0);
    endtask
    task automatic t_record();
        host.rec_write(7'h02, 2, 64'h2000);
        host.rec_write(7'h08, 8, $realtobits(1000.0));
        host.rec_write(7'h10, 8, $realtobits(1000.0));
        host.rec_write(7'h18, 8, $realtobits(7.0));
        host.rec_commit();
        meter_is(0, 1000.0);
        meter_is(1, 1000.0);
        meter_is(2, 0.0);
        // Deferred load of phase 2 apparent meter; phase 1 deselected
        host.rec_write(7'h02, 4, 64'h80800000);
        host.rec_write(7'h50, 8, $realtobits(42.0));
        host.rec_commit();
        meter_is(9, 0.0);
        host.reset_edge();
        meter_is(9, 42.0);
        meter_is(0, 0.0);
        i_l1_supply_ok <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_l1_supply_ok <= 1'b1;
        meter_is(9, 0.0);
    endtask
    task automatic t_regs();
        logic [63:0] v;
        host.rec_read(7'h00, 2, v);
        check("version and pad", 16'h0000, v);
        host.rec_write(7'h00, 2, 64'hFF01);
        host.rec_read(7'h00, 2, v);
        check("version and pad", 16'h0001, v);
    endtask
    // Wrong slot clears meters; a supply loss zeroes the code byte, meters and version
    task automatic t_power();
        logic [63:0] v;
        host.rec_write(7'h08, 8, $realtobits(5.0));
        host.rec_write(7'h03, 1, 64'h60);
        host.rec_commit();
        meter_is(0, 5.0);
        meter_is(2, 7.0);
        i_slot_match <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_slot_match <= 1'b1;
        meter_is(0, 0.0);
        host.rec_commit();
        meter_is(0, 5.0);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        check("code in supply loss", 8'h00, o_in_byte[0]);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_clk);
        check("code after supply", 8'h9F, o_in_byte[0]);
        meter_is(0, 0.0);
        host.rec_read(7'h00, 1, v);
        check("version after supply", 8'h00, v);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_image();
        t_gate();
        t_record();
        t_regs();
        t_power();
        tally_and_finish();
    end
    // Run needs well under 2000 cycles; a hang ends here
    initial begin
        repeat (20000) @(posedge i_clk);
        n_fail++;
        tally_and_finish();
    end
endmodule
bind emu_core emu_monitor mon (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_bus_ok(i_bus_ok),
    .i_layout_reduced(i_layout_reduced), .i_overall_quality_pair(i_overall_quality_pair),
    .i_upper_phase_valid(i_upper_phase_valid), .i_phase_one_current_valid(i_phase_one_current_valid),
    .i_phase_one_voltage_valid(i_phase_one_voltage_valid), .i_phase_one_current(i_phase_one_current),
    .i_power_factor(i_power_factor), .i_rec_addr(i_rec_addr), .i_rec_rd(i_rec_rd), .o_rec_rdata(o_rec_rdata),
    .o_rec_rvalid(o_rec_rvalid), .o_in_byte(o_in_byte));
